// ===== rtl/tpo_pkg.sv
// constants and types of the timed pattern output block
package tpo_pkg;

  // ----------------------------------------
  // register indices (byte address is four times)
  // ----------------------------------------
  localparam logic [15:0] IDX_PATTERN_MODE    = 16'hFFA0;
  localparam logic [15:0] IDX_TRIGGER_CONTROL = 16'hFFA1;
  localparam logic [15:0] IDX_ND_ENABLE_HIGH  = 16'hFFA2;
  localparam logic [15:0] IDX_ND_ENABLE_LOW   = 16'hFFA3;
  localparam logic [15:0] IDX_NEXT_DATA_HIGH  = 16'hFFA4;
  localparam logic [15:0] IDX_NEXT_DATA_LOW   = 16'hFFA5;
  localparam logic [15:0] IDX_NEXT_HIGH_ALT   = 16'hFFA6;
  localparam logic [15:0] IDX_NEXT_LOW_ALT    = 16'hFFA7;
  localparam logic [15:0] IDX_LOW_PORT_DIR    = 16'hFFD1;
  localparam logic [15:0] IDX_LOW_PORT_DATA   = 16'hFFD3;
  localparam logic [15:0] IDX_HIGH_PORT_DIR   = 16'hFFD4;
  localparam logic [15:0] IDX_HIGH_PORT_DATA  = 16'hFFD6;

  // ----------------------------------------
  // reset values and fixed read values
  // ----------------------------------------
  localparam logic [7:0] RST_PATTERN_MODE    = 8'hF0;
  localparam logic [7:0] RST_TRIGGER_CONTROL = 8'hFF;
  localparam logic [7:0] RST_ZERO            = 8'h00;
  localparam logic [3:0] RST_NIBBLE          = 4'h0;
  localparam logic [3:0] RESERVED_NIBBLE     = 4'hF;
  localparam logic [7:0] RESERVED_BYTE       = 8'hFF;
  localparam logic [7:0] WRITE_ONLY_READ     = 8'hFF;

  // ----------------------------------------
  // field layout
  // ----------------------------------------
  localparam int unsigned GROUPS      = 4;
  localparam int unsigned GROUP_W     = 4;
  localparam int unsigned CHANNELS    = 4;
  localparam int unsigned TRIG_SEL_W  = 2;
  localparam int unsigned MODE_NOV_LSB = 0;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [3:0] {
    REG_NONE,
    REG_MODE,
    REG_TRIG,
    REG_NDE_HI,
    REG_NDE_LO,
    REG_ND_HI,
    REG_ND_LO,
    REG_ND_HI_ALT,
    REG_ND_LO_ALT,
    REG_DIR_LO,
    REG_PORT_LO,
    REG_DIR_HI,
    REG_PORT_HI
  } tpo_reg_sel_t;

  typedef struct packed {
    logic                  nonoverlap;
    logic [TRIG_SEL_W-1:0] trig_sel;
    logic [GROUP_W-1:0]    enable;
  } tpo_grp_cfg_t;

endpackage

// ===== rtl/tpo_top.sv
// timed pattern output block with apb register slave
`timescale 1ns/1ns
`default_nettype none

module tpo_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  cmp_match_a,
  input  wire logic [3:0]  cmp_match_b,
  input  wire logic [15:0] port_pin_in,
  output logic      [15:0] pulse_out_pin,
  output logic      [15:0] pulse_out_oe,
  output logic      [3:0]  dma_req
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic tpo_pkg::tpo_reg_sel_t reg_of(input logic [15:0] idx);
    tpo_pkg::tpo_reg_sel_t r;
    r = tpo_pkg::REG_NONE;
    if (idx == tpo_pkg::IDX_PATTERN_MODE) begin
      r = tpo_pkg::REG_MODE;
    end else if (idx == tpo_pkg::IDX_TRIGGER_CONTROL) begin
      r = tpo_pkg::REG_TRIG;
    end else if (idx == tpo_pkg::IDX_ND_ENABLE_HIGH) begin
      r = tpo_pkg::REG_NDE_HI;
    end else if (idx == tpo_pkg::IDX_ND_ENABLE_LOW) begin
      r = tpo_pkg::REG_NDE_LO;
    end else if (idx == tpo_pkg::IDX_NEXT_DATA_HIGH) begin
      r = tpo_pkg::REG_ND_HI;
    end else if (idx == tpo_pkg::IDX_NEXT_DATA_LOW) begin
      r = tpo_pkg::REG_ND_LO;
    end else if (idx == tpo_pkg::IDX_NEXT_HIGH_ALT) begin
      r = tpo_pkg::REG_ND_HI_ALT;
    end else if (idx == tpo_pkg::IDX_NEXT_LOW_ALT) begin
      r = tpo_pkg::REG_ND_LO_ALT;
    end else if (idx == tpo_pkg::IDX_LOW_PORT_DIR) begin
      r = tpo_pkg::REG_DIR_LO;
    end else if (idx == tpo_pkg::IDX_LOW_PORT_DATA) begin
      r = tpo_pkg::REG_PORT_LO;
    end else if (idx == tpo_pkg::IDX_HIGH_PORT_DIR) begin
      r = tpo_pkg::REG_DIR_HI;
    end else if (idx == tpo_pkg::IDX_HIGH_PORT_DATA) begin
      r = tpo_pkg::REG_PORT_HI;
    end
    return r;
  endfunction

  // keep protected bits, take new value elsewhere
  function automatic logic [3:0] merge_nib(input logic [3:0] old_v,
                                           input logic [3:0] new_v,
                                           input logic [3:0] keep);
    return (old_v & keep) | (new_v & ~keep);
  endfunction

  // chosen channel's match out of four
  function automatic logic pick_match(input logic [3:0]                        match,
                                      input logic [tpo_pkg::TRIG_SEL_W-1:0] pick);
    return match[pick];
  endfunction

  // register bits on output pins, pin levels on inputs
  function automatic logic [7:0] pin_view(input logic [7:0] data_v,
                                          input logic [7:0] pin_v,
                                          input logic [7:0] dir_v);
    return (data_v & dir_v) | (pin_v & ~dir_v);
  endfunction

  // non-overlap first half: changing enabled bits go low
  function automatic logic [3:0] drop_changing(input logic [3:0] cur_v,
                                               input logic [3:0] next_v,
                                               input logic [3:0] en_v);
    return cur_v & ~(en_v & (cur_v ^ next_v));
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0]  mode_ff;
  logic [7:0]  trig_ctl_ff;
  logic [7:0]  nde_lo_ff;
  logic [7:0]  nde_hi_ff;
  logic [7:0]  dir_lo_ff;
  logic [7:0]  dir_hi_ff;
  logic [3:0]  port_ff [tpo_pkg::GROUPS];
  logic [3:0]  nd_ff   [tpo_pkg::GROUPS];
  logic [3:0]  nxt_port [tpo_pkg::GROUPS];
  logic [31:0] prdata_ff;
  logic        pslverr_ff;
  logic [3:0]  dma_req_ff;
  logic [3:0]  nxt_dma_req;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  tpo_pkg::tpo_reg_sel_t sel;
  tpo_pkg::tpo_grp_cfg_t cfg [tpo_pkg::GROUPS];
  logic        setup_ph;
  logic        wr_en;
  logic        same_lo;
  logic        same_hi;
  logic [15:0] nde_all;
  logic [15:0] dir_all;
  logic [15:0] port_all;
  logic [3:0]  load_evt;
  logic [7:0]  rd_byte;

  assign sel      = reg_of(paddr[17:2]);
  assign setup_ph = psel & ~penable;
  assign wr_en    = psel & penable & pwrite;
  assign pready   = 1'b1;
  assign prdata   = prdata_ff;
  assign pslverr  = pslverr_ff & psel & penable;

  assign nde_all  = {nde_hi_ff, nde_lo_ff};
  assign dir_all  = {dir_hi_ff, dir_lo_ff};
  assign port_all = {port_ff[3], port_ff[2], port_ff[1], port_ff[0]};
  assign same_lo  = (cfg[0].trig_sel == cfg[1].trig_sel);
  assign same_hi  = (cfg[2].trig_sel == cfg[3].trig_sel);

  // ----------------------------------------
  // pins
  // ----------------------------------------
  assign pulse_out_pin = port_all;
  assign pulse_out_oe  = dir_all;
  assign dma_req       = dma_req_ff;

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= tpo_pkg::RST_PATTERN_MODE;
    end else if (wr_en && sel == tpo_pkg::REG_MODE) begin
      mode_ff <= {tpo_pkg::RESERVED_NIBBLE, pwdata[3:0]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_ctl_ff <= tpo_pkg::RST_TRIGGER_CONTROL;
    end else if (wr_en && sel == tpo_pkg::REG_TRIG) begin
      trig_ctl_ff <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nde_lo_ff <= tpo_pkg::RST_ZERO;
    end else if (wr_en && sel == tpo_pkg::REG_NDE_LO) begin
      nde_lo_ff <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nde_hi_ff <= tpo_pkg::RST_ZERO;
    end else if (wr_en && sel == tpo_pkg::REG_NDE_HI) begin
      nde_hi_ff <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_lo_ff <= tpo_pkg::RST_ZERO;
    end else if (wr_en && sel == tpo_pkg::REG_DIR_LO) begin
      dir_lo_ff <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_hi_ff <= tpo_pkg::RST_ZERO;
    end else if (wr_en && sel == tpo_pkg::REG_DIR_HI) begin
      dir_hi_ff <= pwdata[7:0];
    end
  end

  // ----------------------------------------
  // per-group pattern logic
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : grp
      localparam int unsigned LANE = (g % 2) * 4;
      localparam tpo_pkg::tpo_reg_sel_t ND_MAIN =
        (g < 2) ? tpo_pkg::REG_ND_LO : tpo_pkg::REG_ND_HI;
      localparam tpo_pkg::tpo_reg_sel_t ND_ALT =
        (g < 2) ? tpo_pkg::REG_ND_LO_ALT : tpo_pkg::REG_ND_HI_ALT;
      localparam tpo_pkg::tpo_reg_sel_t PORT_REG =
        (g < 2) ? tpo_pkg::REG_PORT_LO : tpo_pkg::REG_PORT_HI;

      logic same_pair;
      logic nd_we;
      logic port_we;
      logic trig_a;
      logic trig_b;

      assign cfg[g].nonoverlap = mode_ff[tpo_pkg::MODE_NOV_LSB + g];
      assign cfg[g].trig_sel   = trig_ctl_ff[2*g +: 2];
      assign cfg[g].enable     = nde_all[4*g +: 4];

      assign same_pair = (g < 2) ? same_lo : same_hi;
      assign trig_a    = pick_match(cmp_match_a, cfg[g].trig_sel);
      assign trig_b    = pick_match(cmp_match_b, cfg[g].trig_sel);
      assign port_we   = wr_en && sel == PORT_REG;

      // odd group always in the upper nibble of the main address
      if (g % 2 == 1) begin : odd
        assign nd_we = wr_en && sel == ND_MAIN;
      end else begin : even
        assign nd_we = wr_en && (same_pair ? sel == ND_MAIN : sel == ND_ALT);
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          nd_ff[g] <= tpo_pkg::RST_NIBBLE;
        end else if (nd_we) begin
          nd_ff[g] <= pwdata[LANE +: 4];
        end
      end

      // write, then trigger; only enabled bits follow the trigger
      always_comb begin
        nxt_port[g] = port_ff[g];
        if (port_we) begin
          nxt_port[g] = merge_nib(port_ff[g], pwdata[LANE +: 4], cfg[g].enable);
        end
        if (!cfg[g].nonoverlap) begin
          if (trig_a) begin
            nxt_port[g] = merge_nib(nxt_port[g], nd_ff[g], ~cfg[g].enable);
          end
        end else if (trig_b) begin
          nxt_port[g] = merge_nib(nxt_port[g], nd_ff[g], ~cfg[g].enable);
        end else if (trig_a) begin
          nxt_port[g] = drop_changing(nxt_port[g], nd_ff[g], cfg[g].enable);
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          port_ff[g] <= tpo_pkg::RST_NIBBLE;
        end else begin
          port_ff[g] <= nxt_port[g];
        end
      end

      assign load_evt[g] = (|cfg[g].enable) & (cfg[g].nonoverlap ? trig_b : trig_a);
    end
  endgenerate

  // ----------------------------------------
  // dma request per channel
  // ----------------------------------------
  always_comb begin
    nxt_dma_req = 4'h0;
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 4; k++) begin
        if (load_evt[k] && cfg[k].trig_sel == c[1:0]) begin
          nxt_dma_req[c] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_req_ff <= tpo_pkg::RST_NIBBLE;
    end else begin
      dma_req_ff <= nxt_dma_req;
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always_comb begin
    rd_byte = 8'h00;
    if (sel == tpo_pkg::REG_MODE) begin
      rd_byte = mode_ff;
    end else if (sel == tpo_pkg::REG_TRIG) begin
      rd_byte = trig_ctl_ff;
    end else if (sel == tpo_pkg::REG_NDE_HI) begin
      rd_byte = nde_hi_ff;
    end else if (sel == tpo_pkg::REG_NDE_LO) begin
      rd_byte = nde_lo_ff;
    end else if (sel == tpo_pkg::REG_ND_LO) begin
      rd_byte = {nd_ff[1], same_lo ? nd_ff[0] : tpo_pkg::RESERVED_NIBBLE};
    end else if (sel == tpo_pkg::REG_ND_LO_ALT) begin
      if (same_lo) begin
        rd_byte = tpo_pkg::RESERVED_BYTE;
      end else begin
        rd_byte = {tpo_pkg::RESERVED_NIBBLE, nd_ff[0]};
      end
    end else if (sel == tpo_pkg::REG_ND_HI) begin
      rd_byte = {nd_ff[3], same_hi ? nd_ff[2] : tpo_pkg::RESERVED_NIBBLE};
    end else if (sel == tpo_pkg::REG_ND_HI_ALT) begin
      if (same_hi) begin
        rd_byte = tpo_pkg::RESERVED_BYTE;
      end else begin
        rd_byte = {tpo_pkg::RESERVED_NIBBLE, nd_ff[2]};
      end
    end else if (sel == tpo_pkg::REG_DIR_LO || sel == tpo_pkg::REG_DIR_HI) begin
      rd_byte = tpo_pkg::WRITE_ONLY_READ;
    end else if (sel == tpo_pkg::REG_PORT_LO) begin
      rd_byte = pin_view(port_all[7:0], port_pin_in[7:0], dir_lo_ff);
    end else if (sel == tpo_pkg::REG_PORT_HI) begin
      rd_byte = pin_view(port_all[15:8], port_pin_in[15:8], dir_hi_ff);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (setup_ph) begin
      prdata_ff  <= {24'h00_0000, pwrite ? 8'h00 : rd_byte};
      pslverr_ff <= (sel == tpo_pkg::REG_NONE);
    end
  end

endmodule

`default_nettype wire

// ===== tb/tpo_pin_model.sv
// model of the external pins around the pattern outputs
`timescale 1ns/1ns
`default_nettype none

module tpo_pin_model (
  input  wire logic [15:0] pulse_out_pin,
  input  wire logic [15:0] pulse_out_oe,
  input  wire logic [15:0] ext_level,
  output logic      [15:0] port_pin_in
);
  // pin follows the block where driven, else the outside level
  assign port_pin_in = (pulse_out_pin & pulse_out_oe) | (ext_level & ~pulse_out_oe);
endmodule

`default_nettype wire

// ===== tb/tpo_properties.sv
// concurrent checks on the ports of the pattern output block
`timescale 1ns/1ns
`default_nettype none

module tpo_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [3:0]  cmp_match_a,
  input wire logic [3:0]  cmp_match_b,
  input wire logic [15:0] port_pin_in,
  input wire logic [15:0] pulse_out_pin,
  input wire logic [15:0] pulse_out_oe,
  input wire logic [3:0]  dma_req
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  logic [15:0] idx;
  logic        wr_acc;
  logic        rd_set;
  logic        dir_wr;
  logic        port_wr;
  logic        alt_rd;
  logic        any_hit;
  assign idx     = paddr[17:2];
  assign wr_acc  = psel && penable && pwrite;
  assign rd_set  = psel && !penable && !pwrite;
  assign dir_wr  = wr_acc && (idx == tpo_pkg::IDX_LOW_PORT_DIR ||
                              idx == tpo_pkg::IDX_HIGH_PORT_DIR);
  assign port_wr = wr_acc && (idx == tpo_pkg::IDX_LOW_PORT_DATA ||
                              idx == tpo_pkg::IDX_HIGH_PORT_DATA);
  assign alt_rd  = rd_set && (idx == tpo_pkg::IDX_NEXT_LOW_ALT ||
                              idx == tpo_pkg::IDX_NEXT_HIGH_ALT);
  assign any_hit = |(cmp_match_a | cmp_match_b);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_dma_after_match: assert property (
    (dma_req & ~$past(cmp_match_a | cmp_match_b)) == 4'h0)
    else $error("dma request without match");
  a_pins_by_cause: assert property (
    $changed(pulse_out_pin) |-> $past(any_hit || port_wr))
    else $error("pins changed without cause");
  a_oe_from_write: assert property ($changed(pulse_out_oe) |-> $past(dir_wr))
    else $error("output enable changed without write");
  a_oe_low_value: assert property (
    dir_wr && idx == tpo_pkg::IDX_LOW_PORT_DIR |=> pulse_out_oe[7:0] == $past(pwdata[7:0]))
    else $error("low enables differ from write");
  a_unmapped_err: assert property (psel && penable && idx == 16'h0000 |-> pslverr)
    else $error("no error on unmapped access");
  a_mapped_no_err: assert property (
    psel && penable && idx == tpo_pkg::IDX_PATTERN_MODE |-> !pslverr)
    else $error("error on mapped access");
  a_mode_upper_one: assert property (
    rd_set && idx == tpo_pkg::IDX_PATTERN_MODE |=> prdata[7:4] == 4'hF)
    else $error("mode upper bits not one");
  a_alt_reserved_one: assert property (alt_rd |=> prdata[7:4] == 4'hF)
    else $error("reserved next data bits not one");
  a_ready_high: assert property (psel && penable |-> pready)
    else $error("ready low in access phase");

  c_dma: cover property (dma_req != 4'h0);
  c_err: cover property (pslverr);
  c_nonov: cover property (|cmp_match_b ##1 $changed(pulse_out_pin));
endmodule

bind tpo_top tpo_properties u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cmp_match_a(cmp_match_a), .cmp_match_b(cmp_match_b), .port_pin_in(port_pin_in),
  .pulse_out_pin(pulse_out_pin), .pulse_out_oe(pulse_out_oe), .dma_req(dma_req)
);

`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench of the pattern output block
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0]  cmp_match_a, cmp_match_b, dma_req;
  logic [15:0] port_pin_in, pulse_out_pin, pulse_out_oe, ext_level, exp_pin;
  int          error_cnt = 0;
  int          cmp_count = 0;

  tpo_top uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmp_match_a(cmp_match_a), .cmp_match_b(cmp_match_b), .port_pin_in(port_pin_in),
    .pulse_out_pin(pulse_out_pin), .pulse_out_oe(pulse_out_oe), .dma_req(dma_req));
  tpo_pin_model u_pins (.pulse_out_pin(pulse_out_pin), .pulse_out_oe(pulse_out_oe),
    .ext_level(ext_level), .port_pin_in(port_pin_in));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [29:0] i, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      error_cnt++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [15:0] i, input logic [7:0] d);
    apb(1'b1, {14'h0, i}, d);
  endtask

  task automatic rc(input string w, input logic [15:0] i, input logic [7:0] e);
    apb(1'b0, {14'h0, i}, 8'h00);
    chk(w, {8'h00, e}, rd[15:0]);
  endtask

  task automatic fire(input logic [3:0] a, input logic [3:0] b, input logic [3:0] d);
    @(posedge pclk);
    cmp_match_a <= a;
    cmp_match_b <= b;
    @(posedge pclk);
    cmp_match_a <= 4'h0;
    cmp_match_b <= 4'h0;
    #1;
    chk("pins", exp_pin, pulse_out_pin);
    chk("dma", {12'h0, d}, {12'h0, dma_req});
    @(posedge pclk);
    #1;
    chk("pins hold", exp_pin, pulse_out_pin);
    chk("dma end", 16'h0000, {12'h0, dma_req});
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk("pins", 16'h0000, pulse_out_pin);
    chk("oe", 16'h0000, pulse_out_oe);
    chk("dma", 16'h0000, {12'h0, dma_req});
    rc("mode", tpo_pkg::IDX_PATTERN_MODE, 8'hF0);
    rc("trig", tpo_pkg::IDX_TRIGGER_CONTROL, 8'hFF);
    rc("nde_hi", tpo_pkg::IDX_ND_ENABLE_HIGH, 8'h00);
    rc("nde_lo", tpo_pkg::IDX_ND_ENABLE_LOW, 8'h00);
    rc("nd_hi", tpo_pkg::IDX_NEXT_DATA_HIGH, 8'h00);
    rc("nd_lo", tpo_pkg::IDX_NEXT_DATA_LOW, 8'h00);
    rc("nd_lo_alt", tpo_pkg::IDX_NEXT_LOW_ALT, 8'hFF);
    rc("nd_hi_alt", tpo_pkg::IDX_NEXT_HIGH_ALT, 8'hFF);
    rc("dir_lo", tpo_pkg::IDX_LOW_PORT_DIR, 8'hFF);
    rc("port_lo", tpo_pkg::IDX_LOW_PORT_DATA, 8'hC3);
    rc("port_hi", tpo_pkg::IDX_HIGH_PORT_DATA, 8'h5A);
    apb(1'b0, 30'h0, 8'h00);
    chk("unmapped err", 16'h0001, {15'h0, err});
    chk("unmapped data", 16'h0000, rd[15:0]);
    apb(1'b0, {14'h2A5, tpo_pkg::IDX_PATTERN_MODE}, 8'h00);
    chk("alias mode", 16'h00F0, rd[15:0]);
    chk("alias upper", 16'h0000, rd[31:16]);
    chk("alias err", 16'h0000, {15'h0, err});
  endtask

  task automatic t_enable();
    wr(tpo_pkg::IDX_LOW_PORT_DIR, 8'hFF);
    wr(tpo_pkg::IDX_HIGH_PORT_DIR, 8'hFF);
    chk("oe", 16'hFFFF, pulse_out_oe);
    wr(tpo_pkg::IDX_LOW_PORT_DATA, 8'h30);
    chk("pins", 16'h0030, pulse_out_pin);
    wr(tpo_pkg::IDX_ND_ENABLE_LOW, 8'h0F);
    wr(tpo_pkg::IDX_NEXT_DATA_LOW, 8'hA5);
    rc("nd_lo", tpo_pkg::IDX_NEXT_DATA_LOW, 8'hA5);
    exp_pin = 16'h0035;
    fire(4'h8, 4'h0, 4'h8);
    wr(tpo_pkg::IDX_LOW_PORT_DATA, 8'hFF);
    chk("pins", 16'h00F5, pulse_out_pin);
    rc("port_lo", tpo_pkg::IDX_LOW_PORT_DATA, 8'hF5);
  endtask

  task automatic t_groups();
    logic [15:0] nd;
    nd = 16'h967C;
    exp_pin = 16'h00F5;
    wr(tpo_pkg::IDX_TRIGGER_CONTROL, 8'hE4);
    wr(tpo_pkg::IDX_ND_ENABLE_LOW, 8'hFF);
    wr(tpo_pkg::IDX_ND_ENABLE_HIGH, 8'hFF);
    wr(tpo_pkg::IDX_NEXT_DATA_LOW, 8'h7A);
    rc("nd_lo", tpo_pkg::IDX_NEXT_DATA_LOW, 8'h7F);
    wr(tpo_pkg::IDX_NEXT_LOW_ALT, 8'h5C);
    rc("nd_lo_alt", tpo_pkg::IDX_NEXT_LOW_ALT, 8'hFC);
    wr(tpo_pkg::IDX_NEXT_DATA_HIGH, 8'h9B);
    rc("nd_hi", tpo_pkg::IDX_NEXT_DATA_HIGH, 8'h9F);
    wr(tpo_pkg::IDX_NEXT_HIGH_ALT, 8'h36);
    rc("nd_hi_alt", tpo_pkg::IDX_NEXT_HIGH_ALT, 8'hF6);
    for (int g = 0; g < 4; g++) begin
      exp_pin[4*g +: 4] = nd[4*g +: 4];
      fire(4'(1 << g), 4'h0, 4'(1 << g));
    end
  endtask

  task automatic t_nonov();
    wr(tpo_pkg::IDX_PATTERN_MODE, 8'h01);
    rc("mode", tpo_pkg::IDX_PATTERN_MODE, 8'hF1);
    wr(tpo_pkg::IDX_NEXT_LOW_ALT, 8'h03);
    exp_pin = 16'h9670;
    fire(4'h1, 4'h0, 4'h0);
    exp_pin = 16'h9673;
    fire(4'h0, 4'h1, 4'h1);
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    cmp_match_a = 4'h0;
    cmp_match_b = 4'h0;
    ext_level = 16'h5AC3;
    exp_pin = 16'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_enable();
    t_groups();
    t_nonov();
    wrap_up();
  end
endmodule

`default_nettype wire
